// ==== pkg/rxe_pkg.sv ====
// Package: constants and carrier types for the receive error flag control
package rxe_pkg;
    // ------------------------------------------------------------------
    // Command framing
    // ------------------------------------------------------------------
    localparam logic [3:0] RXE_CMD_ADDR = 4'h9;
    localparam int RXE_CMD_ADDR_LSB = 4;
    // ------------------------------------------------------------------
    // Upper data byte field positions
    // ------------------------------------------------------------------
    localparam int RXE_POS_SRC_SEL = 0;
    localparam int RXE_POS_PARITY = 1;
    localparam int RXE_POS_SWITCH_WAIT = 2;
    localparam int RXE_POS_STATUS_RST = 4;
    localparam int RXE_POS_RATE_MASK = 5;
    localparam int RXE_POS_RELEASE_WAIT = 6;
    localparam logic [7:0] RXE_CFG_RESET = 8'h00;
    // ------------------------------------------------------------------
    // Timing: clock 20 MHz, waits in ns, all wait cycle counts round down
    // ------------------------------------------------------------------
    localparam int RXE_CLK_NS = 50;
    localparam int RXE_WAIT_200US_NS = 200000;
    localparam int RXE_WAIT_100US_NS = 100000;
    localparam int RXE_WAIT_50US_NS = 50000;
    localparam int RXE_WAIT_200US_CYC = RXE_WAIT_200US_NS / RXE_CLK_NS;
    localparam int RXE_WAIT_100US_CYC = RXE_WAIT_100US_NS / RXE_CLK_NS;
    localparam int RXE_WAIT_50US_CYC = RXE_WAIT_50US_NS / RXE_CLK_NS;
    // Preamble B counts per release wait code
    localparam int RXE_REL_CNT_00 = 3;
    localparam int RXE_REL_CNT_01 = 24;
    localparam int RXE_REL_CNT_10 = 12;
    localparam int RXE_REL_CNT_11 = 6;
    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] error_release_wait;
        logic rate_change_error_mask;
        logic status_reset_select;
        logic [1:0] clock_switch_wait;
        logic parity_report_mode;
        logic error_source_select;
    } rxe_cfg_t;
    typedef struct packed {
        logic loop_locked;
        logic data_error;
        logic non_pcm;
        logic rate_changed;
        logic rate_from_meas;
        logic osc_stopped;
        logic preamble_b;
    } rxe_stat_t;
endpackage

// ==== src/rxe_wait_timer.sv ====
// Clock switch wait timer started by loss of loop lock
`timescale 1ns/1ps
module rxe_wait_timer
    import rxe_pkg::*;
#(
    parameter int WAIT_200 = RXE_WAIT_200US_CYC,
    parameter int WAIT_100 = RXE_WAIT_100US_CYC,
    parameter int WAIT_50 = RXE_WAIT_50US_CYC
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic unlocked_in,
    input wire logic [1:0] code_in,
    output logic switch_out
);
    localparam int CW = $clog2(WAIT_200 + 1);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] limit;

    // Counter is sized from the longest wait, so order matters
    if (WAIT_200 < WAIT_100 || WAIT_100 < WAIT_50 || WAIT_50 < 1) begin
        $error("rxe_wait_timer: wait counts out of order");
    end

    always_comb begin
        unique case (code_in)
            2'b00: limit = CW'(WAIT_200);
            2'b01: limit = CW'(WAIT_100);
            2'b10: limit = CW'(WAIT_50);
            2'b11: limit = '0;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_r <= '0;
        end else if (!unlocked_in) begin
            cnt_r <= '0;
        end else if (cnt_r < limit) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Code 11 gives limit zero, so switch follows unlock at once
    assign switch_out = unlocked_in && (cnt_r >= limit); // RL3 RL4
endmodule

// ==== src/rxe_error_ctrl.sv ====
// Receive error flag control with serial configuration command
`timescale 1ns/1ps
// Functional notes
// [RL1] Source select 0: flag only for lock loss or data error; the code also raises it for unmasked rate changes.
// [RL2] Source select 1: non-PCM data also raises the flag.
// [RL3] Oscillator switch waits about 200, 100, 50 us for codes 00/01/10.
// [RL4] Switch wait code 11: switch to oscillator at once on unlock.
// [RL5] Rate mask 0: a sampling rate change raises the flag.
// [RL6] Rate mask 1: rate changes do not touch the flag.
// [RL7] After lock, hold flag for 3 (code 00) or 24 (01) preambles.
// [RL8] Release after 12 preambles for code 10, 6 for code 11.
// [RL9] Settings selected by command address 9 in low byte upper nibble.
// [RL10] Mute audio when non-PCM data raises the flag.
// [RL11] Audio output starts only after the flag is released.
// [RL12] Oscillator stopped: use only channel-status rate information.
// [RL13] Upper byte: release wait, mask, status reset, switch wait, parity, src.
// [RL14] Lock loss raises the flag immediately.
module rxe_error_ctrl
    import rxe_pkg::*;
#(
    parameter int WAIT_200 = RXE_WAIT_200US_CYC,
    parameter int WAIT_100 = RXE_WAIT_100US_CYC,
    parameter int WAIT_50 = RXE_WAIT_50US_CYC
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic cmd_valid_in,
    input wire logic [15:0] cmd_word_in,
    input wire rxe_stat_t stat_in,
    output logic receive_error_flag_out,
    output logic audio_enable_out,
    output logic audio_mute_out,
    output logic osc_select_out,
    output logic parity_report_mode_out,
    output logic status_reset_select_out
);
    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    rxe_cfg_t cfg_r;
    logic [4:0] rel_cnt_r;
    logic [4:0] rel_target;
    logic holding_r;
    logic cond_err;
    logic rate_err;
    logic pcm_err;
    logic switch_now;
    logic cmd_hit;
    logic rel_last;
    logic [4:0] rel_cnt_nxt;
    logic flag_nxt;

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    // Timer counter is sized from the longest wait, so order matters
    if (WAIT_200 < WAIT_100 || WAIT_100 < WAIT_50 || WAIT_50 < 1) begin
        $error("rxe_error_ctrl: wait counts out of order");
    end
    // Release counter is five bits wide
    if (RXE_REL_CNT_00 < 1 || RXE_REL_CNT_01 > 31 ||
        RXE_REL_CNT_10 > 31 || RXE_REL_CNT_11 > 31) begin
        $error("rxe_error_ctrl: release count out of range");
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // Words for other setting groups pass by untouched
    always_comb begin
        cmd_hit = cmd_valid_in &&
                  cmd_word_in[RXE_CMD_ADDR_LSB +: 4] == RXE_CMD_ADDR; // RL9
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_r <= rxe_cfg_t'(RXE_CFG_RESET);
        end else if (cmd_hit) begin
            cfg_r <= rxe_cfg_t'(cmd_word_in[15:8]); // RL9 RL13
        end
    end

    // ------------------------------------------------------------------
    // Error conditions
    // ------------------------------------------------------------------
    // Measured rate is meaningless with the oscillator stopped
    always_comb begin
        rate_err = stat_in.rate_changed &&
                   !(stat_in.osc_stopped && stat_in.rate_from_meas) && // RL12
                   !cfg_r.rate_change_error_mask; // RL5 RL6
    end

    always_comb begin
        pcm_err = cfg_r.error_source_select && stat_in.non_pcm; // RL1 RL2
    end

    always_comb begin
        cond_err = !stat_in.loop_locked || stat_in.data_error ||
                   pcm_err || rate_err; // RL14
    end

    // ------------------------------------------------------------------
    // Release target
    // ------------------------------------------------------------------
    always_comb begin
        unique case (cfg_r.error_release_wait)
            2'b00: rel_target = 5'(RXE_REL_CNT_00); // RL7
            2'b01: rel_target = 5'(RXE_REL_CNT_01); // RL7
            2'b10: rel_target = 5'(RXE_REL_CNT_10); // RL8
            2'b11: rel_target = 5'(RXE_REL_CNT_11); // RL8
        endcase
    end

    // ------------------------------------------------------------------
    // Release counting of block-start preambles after lock
    // ------------------------------------------------------------------
    always_comb begin
        rel_cnt_nxt = rel_cnt_r + 5'd1;
        rel_last = holding_r && stat_in.preamble_b &&
                   (rel_cnt_nxt >= rel_target);
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rel_cnt_r <= '0;
        end else if (!stat_in.loop_locked) begin
            rel_cnt_r <= '0;
        end else if (holding_r && stat_in.preamble_b) begin
            rel_cnt_r <= rel_cnt_nxt;
        end
    end

    // Relock alone never clears the hold; preambles must be counted
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            holding_r <= 1'b1;
        end else if (!stat_in.loop_locked) begin
            holding_r <= 1'b1; // RL14
        end else if (rel_last) begin
            holding_r <= 1'b0; // RL7 RL8
        end
    end

    // ------------------------------------------------------------------
    // Flag and audio outputs
    // ------------------------------------------------------------------
    // Lock loss bypasses the hold counter
    always_comb begin
        flag_nxt = cond_err || holding_r; // RL14
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            receive_error_flag_out <= 1'b1;
        end else begin
            receive_error_flag_out <= flag_nxt; // RL14
        end
    end

    // Held audio drops the first samples; a short release wait keeps more
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            audio_enable_out <= 1'b0;
        end else begin
            audio_enable_out <= !flag_nxt; // RL11
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            audio_mute_out <= 1'b1;
        end else begin
            audio_mute_out <= pcm_err || flag_nxt; // RL10
        end
    end

    // ------------------------------------------------------------------
    // Oscillator switch timer
    // ------------------------------------------------------------------
    rxe_wait_timer #(
        .WAIT_200(WAIT_200),
        .WAIT_100(WAIT_100),
        .WAIT_50(WAIT_50)
    ) u_timer (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .unlocked_in(!stat_in.loop_locked),
        .code_in(cfg_r.clock_switch_wait),
        .switch_out(switch_now)
    );

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            osc_select_out <= 1'b0;
        end else begin
            osc_select_out <= switch_now; // RL3 RL4
        end
    end

    // ------------------------------------------------------------------
    // Configuration copies
    // ------------------------------------------------------------------
    // Bits are only carried to pins; their own logic lives elsewhere
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            parity_report_mode_out <= 1'b0;
        end else begin
            parity_report_mode_out <= cfg_r.parity_report_mode; // RL13
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            status_reset_select_out <= 1'b0;
        end else begin
            status_reset_select_out <= cfg_r.status_reset_select; // RL13
        end
    end
endmodule

// ==== sim/rxe_host_model.sv ====
// Controller model issuing setting commands
`timescale 1ns/1ps
module rxe_host_model
    import rxe_pkg::*;
(
    input wire logic clk_in,
    output logic cmd_valid_out,
    output logic [15:0] cmd_word_out
);
    initial begin
        cmd_valid_out = 1'h0;
        cmd_word_out = 16'h0000;
    end
    task automatic send(input logic [3:0] addr, input rxe_cfg_t cfg);
        @(posedge clk_in);
        #1;
        cmd_valid_out = 1'h1;
        cmd_word_out = {cfg, addr, 4'h0};
        @(posedge clk_in);
        #1;
        // Released word shows garbage, not the old value
        cmd_valid_out = 1'h0;
        cmd_word_out = ~cmd_word_out;
    endtask
endmodule

// ==== sim/rxe_error_ctrl_asserts.sv ====
// Checker: port assertions for the receive error flag control
`timescale 1ns/1ps
module rxe_chk
    import rxe_pkg::*;
#(
    parameter int WAIT_200 = 40,
    parameter int WAIT_100 = 20,
    parameter int WAIT_50 = 10
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic cmd_valid_in,
    input wire logic [15:0] cmd_word_in,
    input wire rxe_stat_t stat_in,
    input wire logic receive_error_flag_out,
    input wire logic audio_enable_out,
    input wire logic audio_mute_out,
    input wire logic osc_select_out,
    input wire logic parity_report_mode_out,
    input wire logic status_reset_select_out
);
    logic [7:0] cfg_r;
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_r <= 8'h00;
        end else if (cmd_valid_in && cmd_word_in[7:4] == 4'h9) begin
            cfg_r <= cmd_word_in[15:8];
        end
    end
    // ----
    // Properties
    // ----
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    unlock_flag_a: assert property (!stat_in.loop_locked |=>
        receive_error_flag_out) else $error("flag missed unlock");
    data_flag_a: assert property (stat_in.data_error |=>
        receive_error_flag_out) else $error("flag missed data error");
    npcm_flag_a: assert property (stat_in.non_pcm && cfg_r[0] |=>
        receive_error_flag_out) else $error("flag missed non pcm");
    rate_flag_a: assert property (stat_in.rate_changed && !cfg_r[5] &&
        !(stat_in.osc_stopped && stat_in.rate_from_meas) |=>
        receive_error_flag_out) else $error("flag missed rate change");
    mute_flag_a: assert property (receive_error_flag_out |->
        audio_mute_out) else $error("audio not muted");
    audio_gate_a: assert property (audio_enable_out |->
        !receive_error_flag_out) else $error("audio during error");
    osc_fast_a: assert property (!stat_in.loop_locked &&
        cfg_r[3:2] == 2'h3 |=> ##[0:1] osc_select_out)
        else $error("late oscillator switch");
    osc_wait_a: assert property ($fell(stat_in.loop_locked) &&
        cfg_r[3:2] == 2'h2 |=> !osc_select_out[*8])
        else $error("early oscillator switch");
    cfg_copy_a: assert property ({parity_report_mode_out,
        status_reset_select_out} == {$past(cfg_r[1]), $past(cfg_r[4])})
        else $error("config copy wrong");
    cover property (!stat_in.loop_locked ##1 osc_select_out);
    cover property ($fell(receive_error_flag_out));
    cover property (cmd_valid_in && cmd_word_in[7:4] != 4'h9);
endmodule
bind rxe_error_ctrl rxe_chk #(.WAIT_200(WAIT_200), .WAIT_100(WAIT_100),
    .WAIT_50(WAIT_50)) u_chk (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_word_in(cmd_word_in), .stat_in(stat_in),
    .receive_error_flag_out(receive_error_flag_out),
    .audio_enable_out(audio_enable_out), .audio_mute_out(audio_mute_out),
    .osc_select_out(osc_select_out),
    .parity_report_mode_out(parity_report_mode_out),
    .status_reset_select_out(status_reset_select_out));

// ==== sim/rxe_error_ctrl_tb_top.sv ====
// Testbench for the receive error flag control
`timescale 1ns/1ps
module rxe_error_ctrl_tb_top
    import rxe_pkg::*;
;
    logic sys_clk_in, sys_rst_in, vld, flag, en, mute, osc, par, sts, e_flag;
    logic [15:0] word;
    logic [3:0] a;
    rxe_stat_t st;
    rxe_cfg_t cfg;
    logic [31:0] rnd = 32'hcec0_4530;
    int err_total, samples_checked, cyc;
    int waits [4] = '{40, 20, 10, 0};
    initial begin
        sys_clk_in = 1'h0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    rxe_host_model host (.clk_in(sys_clk_in), .cmd_valid_out(vld),
        .cmd_word_out(word));
    rxe_error_ctrl #(.WAIT_200(40), .WAIT_100(20), .WAIT_50(10)) uut (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .cmd_valid_in(vld), .cmd_word_in(word), .stat_in(st),
        .receive_error_flag_out(flag), .audio_enable_out(en),
        .audio_mute_out(mute), .osc_select_out(osc),
        .parity_report_mode_out(par), .status_reset_select_out(sts));
    // ----
    // Helpers
    // ----
    task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, expv);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic preamble();
        st.preamble_b = 1'h1;
        tick(1);
        st.preamble_b = 1'h0;
        tick(1);
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic int rel_cnt(input logic [1:0] c);
        return c == 2'h0 ? RXE_REL_CNT_00 : c == 2'h1 ? RXE_REL_CNT_01 :
            c == 2'h2 ? RXE_REL_CNT_10 : RXE_REL_CNT_11;
    endfunction
    function automatic logic exp_flag(input rxe_cfg_t c, input rxe_stat_t s);
        return s.data_error | (c.error_source_select & s.non_pcm) |
            (s.rate_changed & !c.rate_change_error_mask &
            !(s.osc_stopped & s.rate_from_meas));
    endfunction
    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        sys_rst_in = 1'h1;
        st = 7'h40;
        tick(3);
        sys_rst_in = 1'h0;
        for (int i = 0; i < 4; i++) begin
            cfg = {i[1:0], 2'h0, i[1:0], 2'h0};
            host.send(4'h9, cfg);
            st.loop_locked = 1'h0;
            if (waits[i] > 0) begin
                tick(waits[i] - 2);
                chk(8'(osc), 8'h00);
            end
            tick(5);
            chk(8'({osc, flag}), 8'h03);
            st.loop_locked = 1'h1;
            tick(1);
            repeat (rel_cnt(i[1:0]) - 1) preamble();
            chk(8'({flag, en}), 8'h02);
            preamble();
            tick(1);
            chk(8'({flag, en, osc}), 8'h02);
        end
        // Random settings, some to foreign addresses that must not stick
        for (int k = 0; k < 60; k++) begin
            rnd = lfsr_next(rnd);
            a = rnd[0] ? 4'h9 : rnd[7:4];
            if (a == 4'h9) cfg = rnd[15:8];
            host.send(a, rnd[15:8]);
            st = {1'h1, rnd[17] & rnd[16], rnd[21:18], 1'h0};
            tick(1);
            e_flag = exp_flag(cfg, st);
            chk(8'({flag, mute, en}),
                8'({e_flag, e_flag, !e_flag}));
            chk(8'({flag, par, sts}), 8'({e_flag,
                cfg.parity_report_mode, cfg.status_reset_select}));
        end
        report_and_stop();
    end
endmodule
